// >>> pkg/bfm_pkg.sv
// types used by the bridge fault monitor; its qualifier uses none of them
// assumes nothing beyond the constants header
package bfm_pkg;

	typedef struct packed {
		logic [10:0] rsvd;
		logic        bootstrap_monitor_mask;
		logic        open_load_current_select;
		logic        qualifier_mode_select;
		logic        stop_on_fault;
		logic        charge_manager_disable;
	} ctrl_s;

	// gate and comparator index: 0 a low, 1 a high, 2 b low, 3 b high
	typedef struct packed {
		logic       reset_pin_active_low;
		logic       ol_cmp;
		logic [1:0] bs_uv;
		logic [1:0] bs_below_off;
		logic [1:0] bs_above_on;
		logic [3:0] ds_cmp;
		logic [3:0] cmd;
	} pin_s;

	typedef enum logic [1:0] {
		BS_IDLE   = 2'b00,
		BS_CHARGE = 2'b01,
		BS_READY  = 2'b10
	} bs_phase_e;

endpackage

// >>> pkg/bfm_regs.svh
// register offsets, field positions, reset values and timing figures of the bridge fault monitor
// assumes a 125 MHz block clock and a word-wide register port with a 4-bit address
`ifndef BFM_REGS_SVH
`define BFM_REGS_SVH

`define BFM_ADDR_W          4
`define BFM_DATA_W          16

`define BFM_CTRL_OFS        4'h0
`define BFM_THRESH_OFS      4'h1
`define BFM_QUAL_OFS        4'h2
`define BFM_STATUS_OFS      4'h3
`define BFM_DIAG1_OFS       4'h4
`define BFM_DIAG2_OFS       4'h5

`define BFM_CTRL_WMASK      16'h001f
`define BFM_CTRL_RST        16'h0000
`define BFM_THRESH_RST      16'h1010
`define BFM_QUAL_RST        16'h0010

`define BFM_THRESH_HI_LSB   0
`define BFM_THRESH_LO_LSB   8
`define BFM_CODE_W          6

`define BFM_DIAG2_OL_BIT    0
`define BFM_DIAG2_BS_LSB    1

`define BFM_CLK_PERIOD_NS   8
`define BFM_OL_TIMEOUT_MS   100
`define BFM_OL_TIMEOUT_CYC  (`BFM_OL_TIMEOUT_MS * 1000000 / `BFM_CLK_PERIOD_NS)
`define BFM_BS_TIMEOUT_US   200
`define BFM_BS_TIMEOUT_CYC  (`BFM_BS_TIMEOUT_US * 1000 / `BFM_CLK_PERIOD_NS)
`define BFM_QUAL_LSB_NS     100
`define BFM_QUAL_CNT_W      10

`define BFM_PIN_RST         16'h8000

`endif

// >>> rtl/bridge_fault_monitor.sv
// bridge fault monitor: open-load timer, bootstrap manager, drain-source fault qualifier and latches
// assumes pins arrive asynchronously; register port is synchronous to clk_i
//
// Summary of operation
// - off-state phase difference timeout sets open-load
// - leaving off-state early resets open-load timer
// - fault flag drops, open-load bit stays
// - charge manager on by default, disable bit
// - defer high side, charge via low side
// - recharge when bootstrap drops below turn-off
// - recharge timeout makes undervoltage valid
// - unmanaged undervoltage valid at once
// - stop-on-fault off: latch, force affected off
// - latch clears by pin, reset, switch-on
// - bootstrap bits clear on diag2 read
// - stop-on-fault on: all off, pin clears
// - mask bit disables bootstrap monitoring
// - two six-bit drain-source threshold codes
// - qualifier time is code times 100ns
// - mode bit selects debounce or blanking
// - debounce timer reaching qualifier time sets bit
// - blanking ignores comparator after turn-on
// - drain-source latch, affected off, clear sources
// - persisting fault re-detected each switch-on
// - drain-source bits clear on diag1 read
// - stop-on-fault on: all off, read clears
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "bfm_regs.svh"
module bridge_fault_monitor #(
	parameter int OL_TIMEOUT_CYC = `BFM_OL_TIMEOUT_CYC,
	parameter int BS_TIMEOUT_CYC = `BFM_BS_TIMEOUT_CYC
) (
	input  wire logic                    clk_i,
	input  wire logic                    reset_n_i,
	input  wire logic [`BFM_ADDR_W-1:0]  addr_i,
	input  wire logic [`BFM_DATA_W-1:0]  wr_data_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [`BFM_DATA_W-1:0]  rd_data_o,
	input  wire logic [3:0]              gate_cmd_i,
	input  wire logic [3:0]              ds_cmp_i,
	input  wire logic [1:0]              bs_above_on_i,
	input  wire logic [1:0]              bs_below_off_i,
	input  wire logic [1:0]              bs_uv_i,
	input  wire logic                    ol_cmp_i,
	input  wire logic                    reset_pin_active_low_i,
	output logic      [3:0]              gate_drive_o,
	output logic                         fault_flag_o,
	output logic      [`BFM_CODE_W-1:0]  high_side_threshold_code_o,
	output logic      [`BFM_CODE_W-1:0]  low_side_threshold_code_o,
	output logic                         open_load_current_select_o
);
	localparam int PIN_W = $bits(bfm_pkg::pin_s);
	localparam int OL_W  = $clog2(OL_TIMEOUT_CYC + 1);
	localparam int BS_W  = $clog2(BS_TIMEOUT_CYC + 1);
	localparam int QW    = `BFM_QUAL_CNT_W;

	if (OL_TIMEOUT_CYC < 2 || BS_TIMEOUT_CYC < 2) begin : g_bad_timeout
		$error("timeout parameters must be at least 2 cycles");
	end

	logic [PIN_W-1:0]        sync1_ff, sync2_ff, sync3_ff, sync_ff;
	bfm_pkg::pin_s           pin;
	bfm_pkg::ctrl_s          ctrl_ff;
	logic [`BFM_DATA_W-1:0]  thresh_ff, qual_ff, rd_data_ff;
	logic [QW-1:0]           qual_cyc_ff;
	logic [3:0]              gate_drive_ff, nxt_gate_drive, cmd_prev_ff, cmd_rise;
	logic [3:0]              ds_valid, ds_state_ff, ds_bit_ff;
	logic [1:0]              bs_valid, bs_state_ff, bs_bit_ff, bs_timeout;
	bfm_pkg::bs_phase_e      bs_phase_ff [2];
	logic [BS_W-1:0]         bs_cnt_ff [2];
	logic                    all_off_ds_ff, all_off_bs_ff, ol_active_ff, ol_bit_ff, fault_flag_ff;
	logic [OL_W-1:0]         ol_cnt_ff;
	logic                    off_state, ol_hit, pin_rst, diag1_rd, diag2_rd, managed, blocked_all;

	function automatic logic [QW-1:0] qual_cycles(input logic [`BFM_CODE_W-1:0] code);
		logic [15:0] t;
		t = 16'(code) * 16'(`BFM_QUAL_LSB_NS) + 16'(`BFM_CLK_PERIOD_NS - 1);
		t = t / 16'(`BFM_CLK_PERIOD_NS);
		if (t == 16'h0000) begin
			t = 16'h0001;
		end
		return t[QW-1:0];
	endfunction

	function automatic logic hit(input logic [`BFM_ADDR_W-1:0] a, input logic [`BFM_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// pin synchroniser: a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sync1_ff <= `BFM_PIN_RST;
			sync2_ff <= `BFM_PIN_RST;
			sync3_ff <= `BFM_PIN_RST;
			sync_ff  <= `BFM_PIN_RST;
		end else begin
			sync1_ff <= {reset_pin_active_low_i, ol_cmp_i, bs_uv_i, bs_below_off_i, bs_above_on_i,
			             ds_cmp_i, gate_cmd_i};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			sync_ff  <= (sync2_ff & sync3_ff) | (sync_ff & (sync2_ff ^ sync3_ff));
		end
	end

	assign pin         = bfm_pkg::pin_s'(sync_ff);
	assign pin_rst     = !pin.reset_pin_active_low;
	assign diag1_rd    = rd_i && hit(addr_i, `BFM_DIAG1_OFS);
	assign diag2_rd    = rd_i && hit(addr_i, `BFM_DIAG2_OFS);
	assign managed     = !ctrl_ff.charge_manager_disable && !ctrl_ff.bootstrap_monitor_mask;
	assign blocked_all = all_off_ds_ff || all_off_bs_ff;
	assign cmd_rise    = pin.cmd & ~cmd_prev_ff;

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ctrl_ff   <= bfm_pkg::ctrl_s'(`BFM_CTRL_RST);
			thresh_ff <= `BFM_THRESH_RST;
			qual_ff   <= `BFM_QUAL_RST;
		end else if (wr_i) begin
			if (hit(addr_i, `BFM_CTRL_OFS)) begin
				ctrl_ff <= bfm_pkg::ctrl_s'(wr_data_i & `BFM_CTRL_WMASK);
			end else if (hit(addr_i, `BFM_THRESH_OFS)) begin
				thresh_ff <= {2'h0, wr_data_i[13:8], 2'h0, wr_data_i[5:0]};
			end else if (hit(addr_i, `BFM_QUAL_OFS)) begin
				qual_ff <= {10'h000, wr_data_i[5:0]};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			qual_cyc_ff <= qual_cycles(`BFM_CODE_W'(`BFM_QUAL_RST));
		end else begin
			qual_cyc_ff <= qual_cycles(qual_ff[`BFM_CODE_W-1:0]);
		end
	end

	// read port: data stand in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rd_data_ff <= '0;
		end else if (rd_i) begin
			if (hit(addr_i, `BFM_CTRL_OFS)) begin
				rd_data_ff <= ctrl_ff;
			end else if (hit(addr_i, `BFM_THRESH_OFS)) begin
				rd_data_ff <= thresh_ff;
			end else if (hit(addr_i, `BFM_QUAL_OFS)) begin
				rd_data_ff <= qual_ff;
			end else if (hit(addr_i, `BFM_STATUS_OFS)) begin
				rd_data_ff <= {2'h0, bs_phase_ff[1] == bfm_pkg::BS_CHARGE, bs_phase_ff[0] == bfm_pkg::BS_CHARGE,
				               gate_drive_ff, ol_active_ff, blocked_all, bs_state_ff, ds_state_ff};
			end else if (hit(addr_i, `BFM_DIAG1_OFS)) begin
				rd_data_ff <= {12'h000, ds_bit_ff};
			end else if (hit(addr_i, `BFM_DIAG2_OFS)) begin
				rd_data_ff <= {13'h0000, bs_bit_ff, ol_bit_ff};
			end else begin
				rd_data_ff <= '0;
			end
		end else begin
			rd_data_ff <= '0;
		end
	end

	// bootstrap manager, one per phase; high side index 2p+1, low side 2p
	for (genvar p = 0; p < 2; p++) begin : g_bs
		logic hi_req;
		assign hi_req        = pin.cmd[2*p+1] && !bs_state_ff[p] && !ds_state_ff[2*p+1] && !blocked_all;
		assign bs_timeout[p] = (bs_phase_ff[p] == bfm_pkg::BS_CHARGE) && (bs_cnt_ff[p] == BS_W'(BS_TIMEOUT_CYC - 1));
		always_ff @(posedge clk_i) begin
			if (!reset_n_i) begin
				bs_phase_ff[p] <= bfm_pkg::BS_IDLE;
			end else begin
				case (bs_phase_ff[p])
					bfm_pkg::BS_IDLE: begin
						if (managed && hi_req) begin
							bs_phase_ff[p] <= pin.bs_above_on[p] ? bfm_pkg::BS_READY : bfm_pkg::BS_CHARGE;
						end
					end
					bfm_pkg::BS_CHARGE: begin
						if (!managed || !hi_req || bs_timeout[p]) begin
							bs_phase_ff[p] <= bfm_pkg::BS_IDLE;
						end else if (pin.bs_above_on[p]) begin
							bs_phase_ff[p] <= bfm_pkg::BS_READY;
						end
					end
					bfm_pkg::BS_READY: begin
						if (!managed || !hi_req) begin
							bs_phase_ff[p] <= bfm_pkg::BS_IDLE;
						end else if (pin.bs_below_off[p]) begin
							bs_phase_ff[p] <= bfm_pkg::BS_CHARGE;
						end
					end
					default: begin
						bs_phase_ff[p] <= bfm_pkg::BS_IDLE;
					end
				endcase
			end
		end
		always_ff @(posedge clk_i) begin
			if (!reset_n_i || bs_phase_ff[p] != bfm_pkg::BS_CHARGE || bs_timeout[p]) begin
				bs_cnt_ff[p] <= '0;
			end else begin
				bs_cnt_ff[p] <= bs_cnt_ff[p] + 1'b1;
			end
		end
		assign bs_valid[p] = !ctrl_ff.bootstrap_monitor_mask &&
		                     (managed ? (bs_timeout[p] && !pin.bs_above_on[p])
		                              : (pin.bs_uv[p] && pin.cmd[2*p+1] && !bs_state_ff[p]));
	end

	// gate drive: fault states force off the affected mosfet or the whole bridge
	always_comb begin
		nxt_gate_drive = 4'h0;
		for (int p = 0; p < 2; p++) begin
			if (pin.cmd[2*p+1] && !bs_state_ff[p] && !bs_valid[p] && !ds_state_ff[2*p+1] &&
			    (!managed || bs_phase_ff[p] == bfm_pkg::BS_READY)) begin
				nxt_gate_drive[2*p+1] = 1'b1;
			end else if ((pin.cmd[2*p] || bs_phase_ff[p] == bfm_pkg::BS_CHARGE) && !ds_state_ff[2*p]) begin
				nxt_gate_drive[2*p] = 1'b1;
			end
		end
		if (blocked_all) begin
			nxt_gate_drive = 4'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			gate_drive_ff <= 4'h0;
			cmd_prev_ff   <= 4'h0;
		end else begin
			gate_drive_ff <= nxt_gate_drive;
			cmd_prev_ff   <= pin.cmd;
		end
	end

	// drain-source qualifiers, one per mosfet
	for (genvar i = 0; i < 4; i++) begin : g_ds
		ds_qualifier #(
			.CNT_W        (QW)
		) u_qual (
			.clk_i        (clk_i),
			.reset_n_i    (reset_n_i),
			.gate_on_i    (gate_drive_ff[i]),
			.cmp_fault_i  (pin.ds_cmp[i]),
			.blank_mode_i (ctrl_ff.qualifier_mode_select),
			.qual_cyc_i   (qual_cyc_ff),
			.valid_o      (ds_valid[i])
		);
	end

	// fault state latches; a new fault wins over any clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ds_state_ff   <= 4'h0;
			bs_state_ff   <= 2'h0;
			all_off_ds_ff <= 1'b0;
			all_off_bs_ff <= 1'b0;
		end else begin
			ds_state_ff   <= (ds_valid & {4{!ctrl_ff.stop_on_fault}}) |
			                 (ds_state_ff & ~({4{pin_rst || diag1_rd}} | cmd_rise));
			bs_state_ff   <= (bs_valid & {2{!ctrl_ff.stop_on_fault}}) |
			                 (bs_state_ff & ~({2{pin_rst}} | {cmd_rise[3], cmd_rise[1]}));
			all_off_ds_ff <= (|ds_valid && ctrl_ff.stop_on_fault) || (all_off_ds_ff && !pin_rst && !diag1_rd);
			all_off_bs_ff <= (|bs_valid && ctrl_ff.stop_on_fault) || (all_off_bs_ff && !pin_rst);
		end
	end

	// diagnostic bits clear only on their word's read
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ds_bit_ff <= 4'h0;
			bs_bit_ff <= 2'h0;
			ol_bit_ff <= 1'b0;
		end else begin
			ds_bit_ff <= ds_valid | (ds_bit_ff & {4{!diag1_rd}});
			bs_bit_ff <= bs_valid | (bs_bit_ff & {2{!diag2_rd}});
			ol_bit_ff <= ol_hit | (ol_bit_ff && !diag2_rd);
		end
	end

	// off-state open-load timer
	assign off_state = (gate_drive_ff == 4'h0);
	assign ol_hit    = off_state && pin.ol_cmp && (ol_cnt_ff == OL_W'(OL_TIMEOUT_CYC - 1));

	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !off_state || !pin.ol_cmp) begin
			ol_cnt_ff <= '0;
		end else if (ol_cnt_ff != OL_W'(OL_TIMEOUT_CYC)) begin
			ol_cnt_ff <= ol_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ol_active_ff <= 1'b0;
		end else begin
			ol_active_ff <= ol_hit || (ol_active_ff && off_state && pin.ol_cmp);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fault_flag_ff <= 1'b0;
		end else begin
			fault_flag_ff <= |ds_state_ff || |bs_state_ff || blocked_all || ol_active_ff;
		end
	end

	assign rd_data_o                  = rd_data_ff;
	assign gate_drive_o               = gate_drive_ff;
	assign fault_flag_o               = fault_flag_ff;
	assign high_side_threshold_code_o = thresh_ff[`BFM_THRESH_HI_LSB +: `BFM_CODE_W];
	assign low_side_threshold_code_o  = thresh_ff[`BFM_THRESH_LO_LSB +: `BFM_CODE_W];
	assign open_load_current_select_o = ctrl_ff.open_load_current_select;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_ds_bit_set: assert property (ds_valid != 4'h0 |=> (ds_bit_ff & $past(ds_valid)) == $past(ds_valid))
		else $error("drain-source bit not set");
	a_ds_force_off: assert property (ds_state_ff != 4'h0 |=> (gate_drive_ff & $past(ds_state_ff)) == 4'h0)
		else $error("faulted mosfet still driven");
	a_all_off_hold: assert property (blocked_all |=> gate_drive_ff == 4'h0)
		else $error("bridge not off under stop-on-fault");
	a_ds_bit_clear: assert property (diag1_rd && ds_valid == 4'h0 |=> ds_bit_ff == 4'h0)
		else $error("diag1 read left bits set");
	a_bs_force_off: assert property (bs_state_ff != 2'h0 |=>
		(gate_drive_ff & {$past(bs_state_ff[1]), 1'b0, $past(bs_state_ff[0]), 1'b0}) == 4'h0)
		else $error("undervoltage mosfet still driven");
	a_bs_unmanaged: assert property (ctrl_ff.charge_manager_disable && !ctrl_ff.bootstrap_monitor_mask &&
		pin.bs_uv[0] && pin.cmd[1] && !bs_state_ff[0] |=> bs_bit_ff[0])
		else $error("unmanaged undervoltage not flagged");
	a_bs_masked: assert property (ctrl_ff.bootstrap_monitor_mask && bs_bit_ff == 2'h0 && !wr_i |=> bs_bit_ff == 2'h0)
		else $error("masked monitor set a bit");
	a_hs_deferred: assert property (managed && bs_phase_ff[0] == bfm_pkg::BS_CHARGE |=> !gate_drive_ff[1])
		else $error("high side driven while charging");
	a_ol_timer_reset: assert property (!off_state |=> ol_cnt_ff == '0)
		else $error("open-load timer not reset");
	a_ol_flag_drop: assert property (ol_active_ff && !off_state |=> !ol_active_ff ##1 $stable(ol_bit_ff) || $past(diag2_rd))
		else $error("open-load state not released");
	a_flag_or: assert property (ol_active_ff || blocked_all |=> fault_flag_ff)
		else $error("fault flag missing");
	a_bs_bound: assert property (bs_cnt_ff[0] <= BS_W'(BS_TIMEOUT_CYC - 1))
		else $error("recharge ran past its timeout");

	c_ds_fault: cover property (ds_valid != 4'h0 ##1 fault_flag_ff);
	c_bs_charge: cover property (bs_phase_ff[0] == bfm_pkg::BS_CHARGE ##1 bs_phase_ff[0] == bfm_pkg::BS_READY);
	c_ol_hit: cover property (ol_hit);
	c_all_off: cover property (blocked_all ##1 !blocked_all);

endmodule

// >>> rtl/ds_qualifier.sv
// drain-source fault qualifier for one mosfet: debounce or blanking timer
// assumes synchronised comparator input and the registered gate drive of its mosfet
`timescale 1ns/1ns
module ds_qualifier #(
	parameter int CNT_W = 10
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             gate_on_i,
	input  wire logic             cmp_fault_i,
	input  wire logic             blank_mode_i,
	input  wire logic [CNT_W-1:0] qual_cyc_i,
	output logic                  valid_o
);
	logic [CNT_W-1:0] cnt_ff;
	logic             done;

	if (CNT_W < 1) begin : g_bad_width
		$error("counter width must be at least 1");
	end

	// debounce restarts on a clean comparator, blanking runs from gate turn-on
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			cnt_ff <= '0;
		end else if (!gate_on_i || (!blank_mode_i && !cmp_fault_i)) begin
			cnt_ff <= '0;
		end else if (cnt_ff != qual_cyc_i) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign done    = (cnt_ff == qual_cyc_i);
	assign valid_o = done && gate_on_i && cmp_fault_i;

endmodule

// >>> verif/bridge_fault_monitor_tb_top.sv
// self-checking bench for the bridge fault monitor
// assumes bridge_model as the external bridge; the bench plays the host
`timescale 1ns/1ns
`include "bfm_regs.svh"
`define CHK(g, e) chk(16'(g), 16'(e))
module bridge_fault_monitor_tb_top;
	logic                   clk_i = 1'b0;
	logic                   reset_n_i = 1'b0;
	logic [`BFM_ADDR_W-1:0] addr_i = '0;
	logic [`BFM_DATA_W-1:0] wr_data_i = '0;
	logic                   wr_i = 1'b0;
	logic                   rd_i = 1'b0;
	logic [`BFM_DATA_W-1:0] rd_data_o;
	logic [3:0]             gate_cmd_i = '0;
	logic [3:0]             ds_cmp_i;
	logic [1:0]             bs_above_on_i;
	logic [1:0]             bs_below_off_i;
	logic [1:0]             bs_uv_i;
	logic                   ol_cmp_i = 1'b0;
	logic                   rst_pin_n = 1'b1;
	logic [3:0]             gate_drive_o;
	logic                   fault_flag_o;
	logic [5:0]             hi_code;
	logic [5:0]             lo_code;
	logic                   ol_sel;
	logic [3:0]             short = '0;
	logic [1:0]             cap_open = '0;
	logic [15:0]            rdat;
	int                     n_fail = 0;
	int                     n_compared = 0;
	int                     cycles = 0;

	always #4 clk_i = ~clk_i;

	bridge_fault_monitor #(.OL_TIMEOUT_CYC(50), .BS_TIMEOUT_CYC(40)) i_dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .gate_cmd_i(gate_cmd_i),
		.ds_cmp_i(ds_cmp_i), .bs_above_on_i(bs_above_on_i), .bs_below_off_i(bs_below_off_i),
		.bs_uv_i(bs_uv_i), .ol_cmp_i(ol_cmp_i), .reset_pin_active_low_i(rst_pin_n),
		.gate_drive_o(gate_drive_o), .fault_flag_o(fault_flag_o),
		.high_side_threshold_code_o(hi_code), .low_side_threshold_code_o(lo_code),
		.open_load_current_select_o(ol_sel)
	);

	bridge_model i_bridge (
		.clk_i(clk_i), .gate_drive_i(gate_drive_o), .short_i(short), .cap_open_i(cap_open),
		.ds_cmp_o(ds_cmp_i), .bs_above_on_o(bs_above_on_i), .bs_below_off_o(bs_below_off_i),
		.bs_uv_o(bs_uv_i)
	);

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rdat = rd_data_o;
	endtask

	task automatic cmd(input logic [3:0] v);
		@(posedge clk_i);
		gate_cmd_i <= v;
	endtask

	// drop all commands and let the pin synchronisers settle
	task automatic off;
		cmd(4'h0);
		repeat (8) @(posedge clk_i);
	endtask

	task automatic glitch(input int k);
		@(posedge clk_i);
		short[k] <= 1'b1;
		repeat (4) @(posedge clk_i);
		short[k] <= 1'b0;
	endtask

	task automatic pin_pulse;
		@(posedge clk_i);
		rst_pin_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		rst_pin_n <= 1'b1;
	endtask

	task automatic await(input logic [3:0] g, input logic f, input int lim);
		for (int i = 0; i < lim && {fault_flag_o, gate_drive_o} !== {f, g}; i++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK({fault_flag_o, gate_drive_o}, {f, g});
	endtask

	task automatic hold(input logic [3:0] g, input logic f, input int n);
		repeat (n) @(posedge clk_i);
		#1;
		`CHK({fault_flag_o, gate_drive_o}, {f, g});
	endtask

	task automatic t_regs;
		rd(`BFM_CTRL_OFS);
		`CHK(rdat, `BFM_CTRL_RST);
		rd(`BFM_THRESH_OFS);
		`CHK(rdat, `BFM_THRESH_RST);
		@(posedge clk_i);
		#1;
		`CHK(rd_data_o, 16'h0000);
		rd(`BFM_QUAL_OFS);
		`CHK(rdat, `BFM_QUAL_RST);
		rd(4'hf);
		`CHK(rdat, 16'h0000);
		`CHK({hi_code, lo_code}, 12'h410);
		wr(`BFM_THRESH_OFS, 16'h2a15);
		wr(`BFM_QUAL_OFS, 16'h003f);
		wr(`BFM_CTRL_OFS, 16'h0008);
		rd(`BFM_QUAL_OFS);
		`CHK(rdat, 16'h003f);
		`CHK({ol_sel, hi_code, lo_code}, 13'h156a);
		wr(`BFM_CTRL_OFS, 16'h0000);
		wr(`BFM_QUAL_OFS, 16'h0002);
		$display("test regs done");
	endtask

	task automatic t_open_load;
		@(posedge clk_i);
		ol_cmp_i <= 1'b1;
		hold(4'h0, 1'b0, 30);
		cmd(4'h1);
		hold(4'h1, 1'b0, 10);
		off();
		hold(4'h0, 1'b0, 22);
		await(4'h0, 1'b1, 40);
		cmd(4'h1);
		await(4'h1, 1'b0, 10);
		off();
		await(4'h0, 1'b1, 60);
		@(posedge clk_i);
		ol_cmp_i <= 1'b0;
		await(4'h0, 1'b0, 10);
		rd(`BFM_DIAG2_OFS);
		`CHK(rdat, 16'h0001);
		rd(`BFM_DIAG2_OFS);
		`CHK(rdat, 16'h0000);
		$display("test open load done");
	endtask

	task automatic t_debounce;
		cmd(4'h1);
		await(4'h1, 1'b0, 10);
		glitch(0);
		hold(4'h1, 1'b0, 40);
		@(posedge clk_i);
		short[0] <= 1'b1;
		await(4'h0, 1'b1, 40);
		off();
		cmd(4'h1);
		await(4'h1, 1'b0, 12);
		await(4'h0, 1'b1, 40);
		off();
		@(posedge clk_i);
		short[0] <= 1'b0;
		rd(`BFM_DIAG1_OFS);
		`CHK(rdat, 16'h0001);
		hold(4'h0, 1'b0, 2);
		rd(`BFM_DIAG1_OFS);
		`CHK(rdat, 16'h0000);
		$display("test debounce done");
	endtask

	task automatic t_blank;
		wr(`BFM_CTRL_OFS, 16'h0004);
		cmd(4'h1);
		await(4'h1, 1'b0, 10);
		glitch(0);
		hold(4'h1, 1'b0, 40);
		glitch(0);
		await(4'h0, 1'b1, 20);
		off();
		rd(`BFM_DIAG1_OFS);
		`CHK(rdat, 16'h0001);
		wr(`BFM_CTRL_OFS, 16'h0000);
		$display("test blanking done");
	endtask

	task automatic t_esf;
		wr(`BFM_CTRL_OFS, 16'h0002);
		cmd(4'h5);
		await(4'h5, 1'b0, 10);
		@(posedge clk_i);
		short[2] <= 1'b1;
		await(4'h0, 1'b1, 40);
		rd(`BFM_STATUS_OFS);
		`CHK(rdat, 16'h0040);
		@(posedge clk_i);
		short[2] <= 1'b0;
		off();
		cmd(4'h5);
		hold(4'h0, 1'b1, 12);
		pin_pulse();
		await(4'h5, 1'b0, 10);
		rd(`BFM_DIAG1_OFS);
		`CHK(rdat, 16'h0004);
		off();
		wr(`BFM_CTRL_OFS, 16'h0000);
		$display("test stop on fault done");
	endtask

	task automatic t_boot;
		@(posedge clk_i);
		cap_open <= 2'b01;
		@(posedge clk_i);
		cap_open <= 2'b00;
		cmd(4'h2);
		await(4'h1, 1'b0, 12);
		await(4'h2, 1'b0, 60);
		await(4'h1, 1'b0, 90);
		await(4'h2, 1'b0, 40);
		off();
		@(posedge clk_i);
		cap_open <= 2'b01;
		cmd(4'h2);
		await(4'h0, 1'b1, 80);
		off();
		hold(4'h0, 1'b1, 4);
		rd(`BFM_DIAG2_OFS);
		`CHK(rdat, 16'h0002);
		rd(`BFM_DIAG2_OFS);
		`CHK(rdat, 16'h0000);
		pin_pulse();
		await(4'h0, 1'b0, 8);
		$display("test bootstrap managed done");
	endtask

	task automatic t_unmanaged;
		wr(`BFM_CTRL_OFS, 16'h0001);
		cmd(4'h6);
		await(4'h4, 1'b1, 12);
		@(posedge clk_i);
		cap_open <= 2'b00;
		cmd(4'h5);
		hold(4'h5, 1'b1, 20);
		cmd(4'h6);
		await(4'h6, 1'b0, 10);
		rd(`BFM_DIAG2_OFS);
		`CHK(rdat, 16'h0002);
		off();
		@(posedge clk_i);
		cap_open <= 2'b01;
		wr(`BFM_CTRL_OFS, 16'h0011);
		cmd(4'h2);
		hold(4'h2, 1'b0, 30);
		off();
		rd(`BFM_DIAG2_OFS);
		`CHK(rdat, 16'h0000);
		wr(`BFM_CTRL_OFS, 16'h0000);
		$display("test bootstrap unmanaged done");
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_open_load();
		t_debounce();
		t_blank();
		t_esf();
		t_boot();
		t_unmanaged();
		end_sim();
	end
endmodule

// >>> verif/bridge_model.sv
// behavioural external bridge: two bootstrap caps and four drain-source comparators
// assumes gate drive index 0 a low, 1 a high, 2 b low, 3 b high
`timescale 1ns/1ns
module bridge_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] gate_drive_i,
	input  wire logic [3:0] short_i,
	input  wire logic [1:0] cap_open_i,
	output logic      [3:0] ds_cmp_o,
	output logic      [1:0] bs_above_on_o,
	output logic      [1:0] bs_below_off_o,
	output logic      [1:0] bs_uv_o
);
	logic [4:0] lvl_ff [2] = '{5'h00, 5'h00};
	logic [1:0] tick_ff = 2'h0;

	// comparator trips only across a conducting shorted mosfet
	assign ds_cmp_o = short_i & gate_drive_i;

	// low side charges fast, high side drains slowly, open cap stays empty
	always_ff @(posedge clk_i) begin
		tick_ff <= tick_ff + 2'h1;
		for (int p = 0; p < 2; p++) begin
			if (cap_open_i[p]) begin
				lvl_ff[p] <= 5'h00;
			end else if (gate_drive_i[2*p]) begin
				lvl_ff[p] <= (lvl_ff[p] > 5'h1d) ? 5'h1f : lvl_ff[p] + 5'h02;
			end else if (gate_drive_i[2*p+1] && tick_ff == 2'h0 && lvl_ff[p] != 5'h00) begin
				lvl_ff[p] <= lvl_ff[p] - 5'h01;
			end
		end
	end

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			bs_above_on_o[p]  = lvl_ff[p] > 5'h18;
			bs_below_off_o[p] = lvl_ff[p] < 5'h10;
			bs_uv_o[p]        = lvl_ff[p] < 5'h08;
		end
	end
endmodule
